// ---- logic/ctc_pkg.sv ----
// constants and types shared by the can timer capture control block
package ctc_pkg;
	localparam int          ADDR_W        = 8;      // axi4-lite address width
	localparam int          CNT_W         = 16;     // counter and capture width
	// register byte offsets
	localparam logic [7:0]  OFS_CONTROL   = 8'h00;  // timer_control
	localparam logic [7:0]  OFS_COUNTER   = 8'h04;  // free_running_counter
	localparam logic [7:0]  OFS_CMP_A     = 8'h08;  // compare_match_reg_a
	localparam logic [7:0]  OFS_OFFSET    = 8'h0c;  // local_offset_reg
	localparam logic [7:0]  OFS_SOF_CAP   = 8'h10;  // sof_capture_reg, read only
	localparam logic [7:0]  OFS_TS_CAP    = 8'h14;  // timestamp_capture_reg, read only
	localparam logic [7:0]  OFS_IRQ_STAT  = 8'h18;  // sticky events, write one to clear
	localparam logic [7:0]  OFS_IRQ_MASK  = 8'h1c;  // interrupt enables
	// timer_control fields
	localparam int          CTL_RUN       = 15;     // counter runs
	localparam int          CTL_SOF_EN    = 14;     // sof_capture_enable
	localparam int          CTL_RX_TS     = 13;     // rx_timestamp_select
	localparam int          CTL_TX_TS     = 12;     // tx_timestamp_select
	localparam int          CTL_CMP_CLR   = 11;     // compare_clear_enable
	localparam int          CTL_ID_CLR    = 10;     // id_match_clear_enable
	localparam int          CTL_ID_DIS    = 9;      // id_match_capture_disable
	localparam int          CTL_PSC_LSB   = 0;      // prescaler field
	localparam int          CTL_PSC_W     = 6;
	localparam logic [15:0] CTL_RSVD_MASK = 16'h01c0; // bits 8 to 6
	localparam logic [15:0] CTL_RESET     = 16'h0000;
	localparam logic [15:0] CNT_RESET     = 16'h0000;
	// interrupt status and mask bits
	localparam int          IRQ_W         = 3;
	localparam int          IRQ_CMP_A     = 0;      // compare_a_irq_flag
	localparam int          IRQ_RX_A      = 1;      // rx_irq_flag_a
	localparam int          IRQ_TS        = 2;      // timestamp captured
	localparam logic [2:0]  IRQ_RESET     = 3'h0;
	// axi responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// write channel state, gray along idle -> addr -> both -> resp
	typedef enum logic [2:0] {
		WR_IDLE = 3'h0,
		WR_ADDR = 3'h1,
		WR_BOTH = 3'h3,
		WR_RESP = 3'h2,
		WR_DATA = 3'h4
	} ctc_wr_state_type;
endpackage

// ---- logic/ctc_count_if.sv ----
// interface between the timer control and its free-running counter
`timescale 1ns/10ps
interface ctc_count_if #(parameter int W = 16);
	logic         tick;        // one count step
	logic         reload;      // clear and set to reloadValue
	logic [W-1:0] reloadValue; // local offset value
	logic         load;        // software write of the counter
	logic [W-1:0] loadValue;   // value written by software
	logic [W-1:0] count;       // present counter value
	modport ctl (output tick, reload, reloadValue, load, loadValue, input count);
	modport cnt (input tick, reload, reloadValue, load, loadValue, output count);
endinterface

// ---- logic/ctc_free_counter.sv ----
// free-running counter with software load and single-cycle reload
`timescale 1ns/10ps
module ctc_free_counter #(
	parameter int W = 16
) (
	input  wire logic clk,
	input  wire logic rst_n,
	ctc_count_if.cnt  port
);
	logic [W-1:0] count_q; // counter state
	logic [W-1:0] count_d; // next value

	////////////////////////////////////////////////////////////////////////
	// software write wins, then reload, then a count tick
	always_comb begin
		count_d = count_q;
		if (port.load) begin
			count_d = port.loadValue;
		end else if (port.reload) begin
			// whole clear-and-set in one cycle, counting resumes next tick
			count_d = port.reloadValue;
		end else if (port.tick) begin
			count_d = count_q + W'(1);
		end
	end

	// register only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= W'(ctc_pkg::CNT_RESET);
		end else begin
			count_q <= count_d;
		end
	end

	assign port.count = count_q;
endmodule // ctc_free_counter

// ---- logic/ctc_timer_control.sv ----
// timer control, capture and axi4-lite register file of the can timer
// Behaviour
// - capture enabled latches counter at each sof
// - identifier compare match clears capture enable
// - receive timestamp on sof or eof
// - transmit timestamp on pending or acknowledge
// - compare match clears counter, loads offset
// - compare match raises its interrupt flag
// - identifier match clears counter, loads offset
// - identifier match itself raises no interrupt
// - auto-disable keeps captured value, clears enable
// - control bits 8 to 6 read zero
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
module ctc_timer_control #(
	parameter int ADDR_W = ctc_pkg::ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// frame events from the protocol engine, one-cycle pulses
	input  wire logic              sofPulse,
	input  wire logic              eofPulse,
	input  wire logic              txPendingPulse,
	input  wire logic              txAckPulse,
	input  wire logic              rxStorePulse,
	input  wire logic              rxIdCompare,
	// interrupt request, level
	output logic                   irq
);
	localparam int CW = ctc_pkg::CNT_W;

	////////////////////////////////////////////////////////////////////////
	// helpers
	// true when the address hits a register word
	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		return (a[1:0] == 2'h0) && (a[ADDR_W-1:5] == '0);
	endfunction

	// byte lanes 0 and 1 as a 16-bit mask
	function automatic logic [15:0] laneMask(input logic [3:0] s);
		return {{8{s[1]}}, {8{s[0]}}};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations
	ctc_count_if #(.W(CW)) cnt ();

	ctc_pkg::ctc_wr_state_type wrState_q, wrState_d; // write channel state
	logic [ADDR_W-1:0] awAddr_q, awAddr_d;  // held write address
	logic [31:0]       wData_q, wData_d;    // held write data
	logic [3:0]        wStrb_q, wStrb_d;    // held byte strobes
	logic [1:0]        bResp_q, bResp_d;    // write response
	logic              rValid_q, rValid_d;  // read data pending
	logic [31:0]       rData_q, rData_d;    // read data
	logic [1:0]        rResp_q, rResp_d;    // read response
	logic [15:0]       ctl_q, ctl_d;        // timer_control
	logic [CW-1:0]     cmpA_q, cmpA_d;      // compare_match_reg_a
	logic [CW-1:0]     ofs_q, ofs_d;        // local_offset_reg
	logic [CW-1:0]     sofCap_q, sofCap_d;  // sof_capture_reg
	logic [CW-1:0]     tsCap_q, tsCap_d;    // timestamp_capture_reg
	logic [2:0]        irqStat_q, irqStat_d; // sticky events
	logic [2:0]        irqMask_q, irqMask_d; // enables
	logic [5:0]        psc_q, psc_d;        // prescaler count
	logic              wrEn;                // register write this cycle
	logic [15:0]       wMask;               // lanes of that write
	logic              idHit;               // store into compare-marked mailbox
	logic              cmpHit;              // compare match on a count tick
	logic              rxTs;                // receive timestamp event
	logic              txTs;                // transmit timestamp event
	logic [31:0]       rdWord;              // read mux

	ctc_free_counter #(.W(CW)) u_counter (
		.clk   (clk),
		.rst_n (rst_n),
		.port  (cnt.cnt)
	);

	////////////////////////////////////////////////////////////////////////
	// axi write channel: address and data taken in either order
	assign s_axi_awready = (wrState_q == ctc_pkg::WR_IDLE) || (wrState_q == ctc_pkg::WR_DATA);
	assign s_axi_wready  = (wrState_q == ctc_pkg::WR_IDLE) || (wrState_q == ctc_pkg::WR_ADDR);
	assign s_axi_bvalid  = (wrState_q == ctc_pkg::WR_RESP);
	assign s_axi_bresp   = bResp_q;
	assign wrEn          = (wrState_q == ctc_pkg::WR_BOTH) && isMapped(awAddr_q);
	assign wMask         = laneMask(wStrb_q);

	// next write state and holding registers
	always_comb begin
		wrState_d = wrState_q;
		awAddr_d  = awAddr_q;
		wData_d   = wData_q;
		wStrb_d   = wStrb_q;
		bResp_d   = bResp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		case (wrState_q)
			ctc_pkg::WR_IDLE: begin
				if (s_axi_awvalid && s_axi_wvalid) begin
					wrState_d = ctc_pkg::WR_BOTH;
				end else if (s_axi_awvalid) begin
					wrState_d = ctc_pkg::WR_ADDR;
				end else if (s_axi_wvalid) begin
					wrState_d = ctc_pkg::WR_DATA;
				end
			end
			ctc_pkg::WR_ADDR: begin
				if (s_axi_wvalid) begin
					wrState_d = ctc_pkg::WR_BOTH;
				end
			end
			ctc_pkg::WR_DATA: begin
				if (s_axi_awvalid) begin
					wrState_d = ctc_pkg::WR_BOTH;
				end
			end
			ctc_pkg::WR_BOTH: begin
				// the write lands at this edge, response follows
				wrState_d = ctc_pkg::WR_RESP;
				bResp_d   = isMapped(awAddr_q) ? ctc_pkg::RESP_OKAY : ctc_pkg::RESP_SLVERR;
			end
			ctc_pkg::WR_RESP: begin
				if (s_axi_bready) begin
					wrState_d = ctc_pkg::WR_IDLE;
				end
			end
			default: wrState_d = ctc_pkg::WR_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// axi read channel: one read at a time, data one edge after address
	assign s_axi_arready = !rValid_q;
	assign s_axi_rvalid  = rValid_q;
	assign s_axi_rdata   = rData_q;
	assign s_axi_rresp   = rResp_q;

	// read mux, reserved bits come back as zero
	always_comb begin
		rdWord = 32'h0;
		case ({s_axi_araddr[4:2], 2'h0})
			5'(ctc_pkg::OFS_CONTROL):  rdWord[15:0] = ctl_q & ~ctc_pkg::CTL_RSVD_MASK;
			5'(ctc_pkg::OFS_COUNTER):  rdWord[15:0] = cnt.count;
			5'(ctc_pkg::OFS_CMP_A):    rdWord[15:0] = cmpA_q;
			5'(ctc_pkg::OFS_OFFSET):   rdWord[15:0] = ofs_q;
			5'(ctc_pkg::OFS_SOF_CAP):  rdWord[15:0] = sofCap_q;
			5'(ctc_pkg::OFS_TS_CAP):   rdWord[15:0] = tsCap_q;
			5'(ctc_pkg::OFS_IRQ_STAT): rdWord[2:0]  = irqStat_q;
			5'(ctc_pkg::OFS_IRQ_MASK): rdWord[2:0]  = irqMask_q;
			default:                   rdWord = 32'h0;
		endcase
	end

	// next read response
	always_comb begin
		rValid_d = rValid_q;
		rData_d  = rData_q;
		rResp_d  = rResp_q;
		if (s_axi_arvalid && !rValid_q) begin
			rValid_d = 1'b1;
			rData_d  = isMapped(s_axi_araddr) ? rdWord : 32'h0;
			rResp_d  = isMapped(s_axi_araddr) ? ctc_pkg::RESP_OKAY : ctc_pkg::RESP_SLVERR;
		end else if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame events and counter control
	assign idHit  = rxStorePulse && rxIdCompare;
	// receive and transmit each pick their trigger; either fills the same register
	assign rxTs   = ctl_q[ctc_pkg::CTL_RX_TS] ? eofPulse : sofPulse;
	assign txTs   = ctl_q[ctc_pkg::CTL_TX_TS] ? txAckPulse : txPendingPulse;
	// a zero compare value never matches, so a cleared register stays quiet
	assign cmpHit = cnt.tick && (cnt.count == cmpA_q) && (cmpA_q != '0);

	assign cnt.tick        = ctl_q[ctc_pkg::CTL_RUN] &&
	                         (psc_q == ctl_q[ctc_pkg::CTL_PSC_LSB +: ctc_pkg::CTL_PSC_W]);
	assign cnt.reloadValue = ofs_q;
	assign cnt.reload      = (cmpHit && ctl_q[ctc_pkg::CTL_CMP_CLR]) ||
	                         (idHit && ctl_q[ctc_pkg::CTL_ID_CLR]);
	assign cnt.load        = wrEn && (awAddr_q[4:0] == 5'(ctc_pkg::OFS_COUNTER));
	assign cnt.loadValue   = (cnt.count & ~wMask) | (wData_q[15:0] & wMask);

	////////////////////////////////////////////////////////////////////////
	// next register file values
	always_comb begin
		ctl_d     = ctl_q;
		cmpA_d    = cmpA_q;
		ofs_d     = ofs_q;
		sofCap_d  = sofCap_q;
		tsCap_d   = tsCap_q;
		irqStat_d = irqStat_q;
		irqMask_d = irqMask_q;
		// prescaler divides the clock by field plus one
		psc_d = (cnt.tick || !ctl_q[ctc_pkg::CTL_RUN]) ? 6'h0 : psc_q + 6'h1;
		if (wrEn) begin
			case (awAddr_q[4:0])
				5'(ctc_pkg::OFS_CONTROL): begin
					// reserved bits are never stored
					ctl_d = ((ctl_q & ~wMask) | (wData_q[15:0] & wMask)) &
					        ~ctc_pkg::CTL_RSVD_MASK;
				end
				5'(ctc_pkg::OFS_CMP_A):    cmpA_d = (cmpA_q & ~wMask) | (wData_q[15:0] & wMask);
				5'(ctc_pkg::OFS_OFFSET):   ofs_d = (ofs_q & ~wMask) | (wData_q[15:0] & wMask);
				5'(ctc_pkg::OFS_IRQ_STAT): begin
					if (wStrb_q[0]) begin
						irqStat_d = irqStat_q & ~wData_q[2:0];
					end
				end
				5'(ctc_pkg::OFS_IRQ_MASK): begin
					if (wStrb_q[0]) begin
						irqMask_d = wData_q[2:0];
					end
				end
				default: ; // capture registers and counter are not stored here
			endcase
		end
		// capture only while enabled; when disabled the old value is kept
		if (ctl_q[ctc_pkg::CTL_SOF_EN] && sofPulse) begin
			sofCap_d = cnt.count;
		end
		// storing into a compare-marked mailbox drops the enable, value kept;
		// the hardware clear beats a software write in the same cycle
		if (idHit && ctl_q[ctc_pkg::CTL_ID_DIS]) begin
			ctl_d[ctc_pkg::CTL_SOF_EN] = 1'b0;
		end
		if (rxTs || txTs) begin
			tsCap_d = cnt.count;
		end
		// events set after the clear so a coincident event survives
		if (cmpHit) begin
			irqStat_d[ctc_pkg::IRQ_CMP_A] = 1'b1;
		end
		// only the receive flag reports a stored message, never the id match
		if (rxStorePulse) begin
			irqStat_d[ctc_pkg::IRQ_RX_A] = 1'b1;
		end
		if (rxTs || txTs) begin
			irqStat_d[ctc_pkg::IRQ_TS] = 1'b1;
		end
	end

	assign irq = |(irqStat_q & irqMask_q);

	////////////////////////////////////////////////////////////////////////
	// register all state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrState_q <= ctc_pkg::WR_IDLE;
			awAddr_q  <= '0;
			wData_q   <= 32'h0;
			wStrb_q   <= 4'h0;
			bResp_q   <= ctc_pkg::RESP_OKAY;
			rValid_q  <= 1'b0;
			rData_q   <= 32'h0;
			rResp_q   <= ctc_pkg::RESP_OKAY;
			ctl_q     <= ctc_pkg::CTL_RESET;
			cmpA_q    <= ctc_pkg::CNT_RESET;
			ofs_q     <= ctc_pkg::CNT_RESET;
			sofCap_q  <= ctc_pkg::CNT_RESET;
			tsCap_q   <= ctc_pkg::CNT_RESET;
			irqStat_q <= ctc_pkg::IRQ_RESET;
			irqMask_q <= ctc_pkg::IRQ_RESET;
			psc_q     <= 6'h0;
		end else begin
			wrState_q <= wrState_d;
			awAddr_q  <= awAddr_d;
			wData_q   <= wData_d;
			wStrb_q   <= wStrb_d;
			bResp_q   <= bResp_d;
			rValid_q  <= rValid_d;
			rData_q   <= rData_d;
			rResp_q   <= rResp_d;
			ctl_q     <= ctl_d;
			cmpA_q    <= cmpA_d;
			ofs_q     <= ofs_d;
			sofCap_q  <= sofCap_d;
			tsCap_q   <= tsCap_d;
			irqStat_q <= irqStat_d;
			irqMask_q <= irqMask_d;
			psc_q     <= psc_d;
		end
	end
endmodule // ctc_timer_control

// ---- bench/ctc_timer_control_asserts.sv ----
// port-level checker for the can timer control block
`timescale 1ns/10ps
module ctc_timer_control_asserts #(
	parameter int ADDR_W = 8
) (
	input logic              clk,
	input logic              rst_n,
	input logic              s_axi_awvalid,
	input logic              s_axi_awready,
	input logic              s_axi_wvalid,
	input logic              s_axi_wready,
	input logic [1:0]        s_axi_bresp,
	input logic              s_axi_bvalid,
	input logic              s_axi_bready,
	input logic [ADDR_W-1:0] s_axi_araddr,
	input logic              s_axi_arvalid,
	input logic              s_axi_arready,
	input logic [31:0]       s_axi_rdata,
	input logic [1:0]        s_axi_rresp,
	input logic              s_axi_rvalid,
	input logic              s_axi_rready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// both write halves taken at one edge, or a read taken
	sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
	// the write lands one edge after both halves are held; bvalid rises with it
	property p_wr_resp; s_wr |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	property p_b_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	property p_rd_resp; s_rd |=> s_axi_rvalid; endproperty
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
	// unmapped space answers with an error and zero data
	property p_unmapped; s_rd and s_axi_araddr >= 8'h20 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	property p_rsvd; s_rd and s_axi_araddr == 8'h00 |=> s_axi_rdata[8:6] == 3'h0;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no write response");
	a_b_hold: assert property (p_b_hold) else $error("write response not held");
	a_b_drop: assert property (p_b_drop) else $error("write response not released");
	a_b_refuse: assert property (p_b_refuse) else $error("write taken while answering");
	a_rd_resp: assert property (p_rd_resp) else $error("no read response");
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while answering");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	a_rsvd: assert property (p_rsvd) else $error("reserved control bits not zero");
endmodule // ctc_timer_control_asserts

bind ctc_timer_control ctc_timer_control_asserts #(.ADDR_W(ADDR_W)) ctc_timer_control_asserts_inst (
	.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ---- bench/can_timer_capture_control_tb.sv ----
// self-checking bench for the can timer control block
`timescale 1ns/10ps
module can_timer_capture_control_tb;
	logic clk = 0, rst_n = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq;
	logic sofPulse = 0, eofPulse = 0, txPendingPulse = 0, txAckPulse = 0, rxStorePulse = 0;
	logic rxIdCompare = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, brsp, rrsp;
	logic [4:0] rxe, txe, rxw, txw; // selected and unselected events
	int n_errors = 0, samples_checked = 0;
	// event masks in the order sof, eof, tx pending, tx ack, rx store
	localparam logic [4:0] E_SOF = 5'h10, E_EOF = 5'h08, E_TXP = 5'h04, E_TXA = 5'h02, E_RX = 5'h01;
	always #50 clk = ~clk;
	ctc_timer_control ctc_timer_control_inst (
		.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sofPulse, .eofPulse, .txPendingPulse,
		.txAckPulse, .rxStorePulse, .rxIdCompare, .irq);
	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// readies are sampled mid-cycle: they only move on the rising edge
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		ah = 0; wh = 0; bh = 0;
		@(posedge clk);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
		while (!(ah && wh)) begin
			@(negedge clk);
			if (s_axi_awready) ah = 1'b1;
			if (s_axi_wready) wh = 1'b1;
			@(posedge clk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b1;
		while (!bh) begin
			@(negedge clk); bh = s_axi_bvalid; brsp = s_axi_bresp; @(posedge clk);
		end
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		logic h;
		h = 0;
		@(posedge clk);
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
		while (!h) begin
			@(negedge clk); h = s_axi_arready; @(posedge clk);
		end
		s_axi_arvalid <= 1'b0; s_axi_rready <= 1'b1; h = 0;
		while (!h) begin
			@(negedge clk); h = s_axi_rvalid; rdat = s_axi_rdata; rrsp = s_axi_rresp; @(posedge clk);
		end
		s_axi_rready <= 1'b0;
	endtask
	task rc(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a); chk(n, e, rdat);
	endtask
	// one-cycle event pulse, id compare level alongside
	task pulse(input logic [4:0] m, input logic c);
		@(posedge clk);
		{sofPulse, eofPulse, txPendingPulse, txAckPulse, rxStorePulse} <= m; rxIdCompare <= c;
		@(posedge clk);
		{sofPulse, eofPulse, txPendingPulse, txAckPulse, rxStorePulse} <= 5'h0; rxIdCompare <= 1'b0;
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rc("ctl0", 8'h00, 32'h0); rc("stat0", 8'h18, 32'h0); chk("irq0", 32'h0, {31'h0, irq});
		wr(8'h00, 32'h01c0); rc("rsvd", 8'h00, 32'h0);
		rd(8'h20); chk("errresp", 32'h2, {30'h0, rrsp}); chk("errdata", 32'h0, rdat);
		wr(8'h10, 32'h5a5a); chk("robresp", 32'h0, {30'h0, brsp}); rc("ro", 8'h10, 32'h0);
		// capture follows the enable bit, value kept when disabled
		wr(8'h00, 32'h4000); wr(8'h04, 32'h1234); pulse(E_SOF, 0);
		rc("sofcap", 8'h10, 32'h1234);
		wr(8'h00, 32'h0); wr(8'h04, 32'h5555); pulse(E_SOF, 0);
		rc("sofkeep", 8'h10, 32'h1234);
		wr(8'h00, 32'h4200); pulse(E_RX, 0); rc("nodis", 8'h00, 32'h4200);
		pulse(E_RX, 1); rc("autodis", 8'h00, 32'h0200);
		pulse(E_SOF, 0); rc("retain", 8'h10, 32'h1234);
		wr(8'h00, 32'h4000); pulse(E_RX, 1); rc("keepen", 8'h00, 32'h4000);
		// id match alone is silent; rx store raises, mask hides, clear drops
		wr(8'h18, 32'h7); wr(8'h1c, 32'h2); pulse(5'h0, 1);
		rc("idonly", 8'h18, 32'h0);
		pulse(E_RX, 1); rc("rxflag", 8'h18, 32'h2); chk("irqrx", 32'h1, {31'h0, irq});
		wr(8'h1c, 32'h0); chk("irqmask", 32'h0, {31'h0, irq});
		wr(8'h1c, 32'h2); chk("irqon", 32'h1, {31'h0, irq});
		wr(8'h18, 32'h2); chk("irqclr", 32'h0, {31'h0, irq});
		// id match reload with the counter stopped
		wr(8'h00, 32'h0); wr(8'h0c, 32'h77); wr(8'h04, 32'h5); pulse(E_RX, 1);
		rc("noreload", 8'h04, 32'h5);
		wr(8'h00, 32'h0400); pulse(E_RX, 1); rc("reload", 8'h04, 32'h77);
		// every timestamp select combination, wrong events ignored
		for (int i = 0; i < 4; i++) begin
			rxe = i[1] ? E_EOF : E_SOF; rxw = i[1] ? E_SOF : E_EOF;
			txe = i[0] ? E_TXA : E_TXP; txw = i[0] ? E_TXP : E_TXA;
			wr(8'h00, {18'h0, i[1:0], 12'h0}); wr(8'h04, 32'h100 + i); pulse(rxe, 0);
			rc("rxts", 8'h14, 32'h100 + i);
			wr(8'h04, 32'h200 + i); pulse(txe, 0); rc("txts", 8'h14, 32'h200 + i);
			wr(8'h04, 32'h300); pulse(rxw | txw, 0); rc("tsidle", 8'h14, 32'h200 + i);
		end
		// software keeps receive stamps on end of frame, select bit still 1 here
		wr(8'h04, 32'h44); pulse(E_EOF | E_RX, 0); rc("rxeof", 8'h14, 32'h44);
		// compare match clears to the offset, so the count stays in 10..20
		wr(8'h18, 32'h7); wr(8'h1c, 32'h1); wr(8'h0c, 32'h10); wr(8'h08, 32'h20); wr(8'h04, 32'h1c);
		wr(8'h00, 32'h8800); repeat (40) @(posedge clk); wr(8'h00, 32'h0);
		rd(8'h04); chk("wrap", 32'h1, {31'h0, rdat >= 32'h10 && rdat <= 32'h20});
		chk("cmpirq", 32'h1, {31'h0, irq});
		wr(8'h18, 32'h7); wr(8'h04, 32'h1c); wr(8'h00, 32'h8000); repeat (40) @(posedge clk);
		wr(8'h00, 32'h0); rd(8'h04); chk("noclr", 32'h1, {31'h0, rdat > 32'h20});
		report_and_stop;
	end
endmodule // can_timer_capture_control_tb
